// *** logic/psbs_top.sv ***
// parallel slave port byte buffers with empty/full status, apb registers and interrupt
`default_nettype none
module psbs_top #(
  parameter int unsigned SLOTS_P = psbs_pkg::SLOTS
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire psbs_pkg::psbs_apb_req_s apb_req,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire psbs_pkg::psbs_host_req_s host_req,
  output logic [psbs_pkg::BYTE_W-1:0] host_rdata,
  output logic [psbs_pkg::PAD_W-1:0] pad_cfg,
  output logic irq
);
  import psbs_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [SLOTS-1:0] slot_onehot(input logic [SLOT_W-1:0] a);
    slot_onehot = '0;
    slot_onehot[a] = 1'b1;
  endfunction : slot_onehot

  function automatic logic slot_window(input logic [ADDR_W-1:0] a,
                                       input logic [ADDR_W-1:0] base);
    slot_window = (a[ADDR_W-1:4] == base[ADDR_W-1:4]) && (a[1:0] == 2'h0);
  endfunction : slot_window

  ////////////////////////////////////////////////////////////////////////////////
  // bus decode
  wire logic setup = apb_req.psel & ~apb_req.penable;
  wire logic access = apb_req.psel & apb_req.penable;
  wire logic wr_acc = access & apb_req.pwrite;
  wire logic rd_acc = access & ~apb_req.pwrite;
  wire logic [ADDR_W-1:0] paddr = apb_req.paddr;
  wire logic [31:0] pwdata = apb_req.pwdata;
  wire logic [SLOT_W-1:0] bus_slot = paddr[3:2];
  wire logic hit_stat = paddr == OFF_STAT;
  wire logic hit_ist = paddr == OFF_IRQ_STAT;
  wire logic hit_imask = paddr == OFF_IRQ_MASK;
  wire logic hit_pad = paddr == OFF_PAD_CFG;
  wire logic hit_out = slot_window(paddr, OFF_OUT_BASE);
  wire logic hit_in = slot_window(paddr, OFF_IN_BASE);
  wire logic mapped = hit_stat | hit_ist | hit_imask | hit_pad | hit_out | hit_in;

  // every access completes without wait states
  assign pready = 1'b1;
  assign pslverr = access & ~mapped;

  ////////////////////////////////////////////////////////////////////////////////
  // state
  logic [SLOTS-1:0] out_empty_q;
  logic [SLOTS-1:0] out_empty_d;
  logic [SLOTS-1:0] in_full_q;
  logic [SLOTS-1:0] in_full_d;
  logic out_unf_q;
  logic out_unf_d;
  logic in_ovf_q;
  logic in_ovf_d;
  logic [EV_W-1:0] ist_q;
  logic [EV_W-1:0] ist_d;
  logic [EV_W-1:0] imask_q;
  logic [PAD_W-1:0] pad_q;
  logic [31:0] prdata_q;
  logic rd_mem_q;
  logic [BYTE_W-1:0] in_rdata;

  ////////////////////////////////////////////////////////////////////////////////
  // output side: software fills, host drains
  wire logic [SLOTS-1:0] host_rd_slot = slot_onehot(host_req.addr) & {SLOTS{host_req.rd}};
  wire logic [SLOTS-1:0] sw_out_wr = slot_onehot(bus_slot) & {SLOTS{wr_acc & hit_out}};
  wire logic unf_set = host_req.rd & out_empty_q[host_req.addr];
  wire logic stat_wr = wr_acc & hit_stat;
  // fresh data wins over a host read of the same slot in the same cycle
  assign out_empty_d = (out_empty_q | host_rd_slot) & ~sw_out_wr;
  // only a written zero clears; a one leaves the flag alone
  assign out_unf_d = unf_set | (out_unf_q & ~(stat_wr & ~pwdata[BIT_OUT_UNF]));

  ////////////////////////////////////////////////////////////////////////////////
  // input side: host fills, software drains
  wire logic host_slot_full = in_full_q[host_req.addr];
  wire logic host_wr_ok = host_req.wr & ~host_slot_full;
  wire logic [SLOTS-1:0] host_wr_slot = slot_onehot(host_req.addr) & {SLOTS{host_wr_ok}};
  wire logic [SLOTS-1:0] sw_in_rd = slot_onehot(bus_slot) & {SLOTS{rd_acc & hit_in}};
  wire logic ovf_set = host_req.wr & host_slot_full;
  // a full slot keeps its unread byte: the overflowing write is dropped
  assign in_full_d = (in_full_q & ~sw_in_rd) | host_wr_slot;
  assign in_ovf_d = ovf_set | (in_ovf_q & ~(stat_wr & ~pwdata[BIT_IN_OVF]));

  wire logic [15:0] stat_word = {&in_full_q, in_ovf_q, 2'h0, in_full_q,
                                 &out_empty_q, out_unf_q, 2'h0, out_empty_q};

  ////////////////////////////////////////////////////////////////////////////////
  // interrupt status, write one to clear; a new event beats the clear
  wire logic [EV_W-1:0] events = {host_wr_ok, host_req.rd & ~out_empty_q[host_req.addr],
                                  ovf_set, unf_set};
  wire logic [EV_W-1:0] ist_clr = {EV_W{wr_acc & hit_ist}} & pwdata[EV_W-1:0];
  assign ist_d = events | (ist_q & ~ist_clr);
  assign irq = |(ist_q & imask_q);

  ////////////////////////////////////////////////////////////////////////////////
  // read data is captured in the setup phase so the access phase needs no wait
  wire logic [31:0] reg_rdata = hit_stat ? {16'h0, stat_word} :
                                hit_ist ? {28'h0, ist_q} :
                                hit_imask ? {28'h0, imask_q} :
                                hit_pad ? {29'h0, pad_q} : 32'h0;
  assign prdata = rd_mem_q ? {24'h0, in_rdata} : prdata_q;
  assign pad_cfg = pad_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_empty_q <= RST_OUT_EMPTY;
      in_full_q <= RST_IN_FULL;
      out_unf_q <= 1'b0;
      in_ovf_q <= 1'b0;
    end else begin
      out_empty_q <= out_empty_d;
      in_full_q <= in_full_d;
      out_unf_q <= out_unf_d;
      in_ovf_q <= in_ovf_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ist_q <= '0;
      imask_q <= RST_IRQ_MASK;
      pad_q <= RST_PAD_CFG;
    end else begin
      ist_q <= ist_d;
      if (wr_acc && hit_imask) begin
        imask_q <= pwdata[EV_W-1:0];
      end
      if (wr_acc && hit_pad) begin
        pad_q <= pwdata[PAD_W-1:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= RST_RDATA;
      rd_mem_q <= 1'b0;
    end else if (setup) begin
      prdata_q <= reg_rdata;
      rd_mem_q <= hit_in & ~apb_req.pwrite;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // byte stores
  psbs_mem #(.WIDTH(BYTE_W), .DEPTH(SLOTS_P), .AW(SLOT_W)) u_out_mem (
    .pclk(pclk),
    .presetn(presetn),
    .we(wr_acc & hit_out),
    .waddr(bus_slot),
    .wdata(pwdata[BYTE_W-1:0]),
    .re(host_req.rd),
    .raddr(host_req.addr),
    .rdata_q(host_rdata)
  );

  psbs_mem #(.WIDTH(BYTE_W), .DEPTH(SLOTS_P), .AW(SLOT_W)) u_in_mem (
    .pclk(pclk),
    .presetn(presetn),
    .we(host_wr_ok),
    .waddr(host_req.addr),
    .wdata(host_req.wdata),
    .re(setup & hit_in & ~apb_req.pwrite),
    .raddr(bus_slot),
    .rdata_q(in_rdata)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_sw_fill0;
    wr_acc && hit_out && bus_slot == 2'h0;
  endsequence

  sequence s_host_drain0;
    host_req.rd && host_req.addr == 2'h0 && !(wr_acc && hit_out);
  endsequence

  a_underflow_set: assert property (
    host_req.rd && out_empty_q[host_req.addr] |=> out_unf_q && stat_word[BIT_OUT_UNF])
    else $error("underflow flag not set by host read of empty slot");

  a_underflow_sticky: assert property (
    out_unf_q && !(stat_wr && !pwdata[BIT_OUT_UNF]) |=> out_unf_q)
    else $error("underflow flag dropped without a software zero write");

  a_underflow_clear: assert property (
    stat_wr && !pwdata[BIT_OUT_UNF] && !unf_set |=> !out_unf_q)
    else $error("underflow flag not cleared by software zero write");

  a_empty_clear: assert property (
    wr_acc && hit_out |=> !out_empty_q[$past(bus_slot)] && !stat_word[BIT_OUT_ALL_EMPTY])
    else $error("software write left the slot empty");

  a_slot_cycle: assert property (
    s_sw_fill0 ##1 s_host_drain0 |=> out_empty_q[0] && !$rose(out_unf_q))
    else $error("slot not empty after host read, or false underflow");

  a_overflow_set: assert property (
    host_req.wr && in_full_q[host_req.addr] |=> in_ovf_q ##1 (in_ovf_q || $past(stat_wr)))
    else $error("overflow flag not set or lost");

  a_full_cycle: assert property (
    rd_acc && hit_in && !host_req.wr |=> !in_full_q[$past(bus_slot)])
    else $error("full flag not cleared by software read");

  a_full_set: assert property (
    // a software read of the same full slot in that cycle empties it and the write is dropped
    host_req.wr && !(rd_acc && hit_in && bus_slot == host_req.addr) |=>
      in_full_q[$past(host_req.addr)] && stat_word[LSB_IN_FULL + $past(host_req.addr)])
    else $error("host write did not leave slot full");
endmodule : psbs_top
`default_nettype wire

// *** include/psbs_pkg.sv ***
// package: register map, field layout and carriers of the parallel slave buffer status block
// Operation
// - host read of empty out slot sets underflow
// - underflow stays set until software writes zero
// - software write to out slot clears empty
// - empty reads zero while unread data held
`default_nettype none
package psbs_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned SLOTS = 4;
  localparam int unsigned BYTE_W = 8;
  localparam int unsigned SLOT_W = 2;
  localparam int unsigned EV_W = 4;
  localparam int unsigned PAD_W = 3;

  // apb byte offsets
  localparam logic [ADDR_W-1:0] OFF_STAT = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_IRQ_STAT = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_IRQ_MASK = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_PAD_CFG = 8'h0c;
  localparam logic [ADDR_W-1:0] OFF_OUT_BASE = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_IN_BASE = 8'h20;

  // buffer status word layout
  localparam int unsigned BIT_IN_ALL_FULL = 15;
  localparam int unsigned BIT_IN_OVF = 14;
  localparam int unsigned LSB_IN_FULL = 8;
  localparam int unsigned BIT_OUT_ALL_EMPTY = 7;
  localparam int unsigned BIT_OUT_UNF = 6;
  localparam int unsigned LSB_OUT_EMPTY = 0;

  // interrupt event positions
  localparam int unsigned EV_UNDERFLOW = 0;
  localparam int unsigned EV_OVERFLOW = 1;
  localparam int unsigned EV_HOST_READ = 2;
  localparam int unsigned EV_HOST_WRITE = 3;

  // values after reset
  localparam logic [SLOTS-1:0] RST_OUT_EMPTY = 4'hf;
  localparam logic [SLOTS-1:0] RST_IN_FULL = 4'h0;
  localparam logic [EV_W-1:0] RST_IRQ_MASK = 4'h0;
  localparam logic [PAD_W-1:0] RST_PAD_CFG = 3'h0;
  localparam logic [31:0] RST_RDATA = 32'h0;

  // one host bus cycle as seen on the synchronous pins
  typedef struct packed {
    logic rd;
    logic wr;
    logic [SLOT_W-1:0] addr;
    logic [BYTE_W-1:0] wdata;
  } psbs_host_req_s;

  // apb request from the master
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0] pwdata;
  } psbs_apb_req_s;
endpackage : psbs_pkg
`default_nettype wire

// *** logic/psbs_mem.sv ***
// small byte memory with one write port and a registered read port
`default_nettype none
module psbs_mem #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 4,
  parameter int unsigned AW = 2
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [WIDTH-1:0] wdata,
  input wire logic re,
  input wire logic [AW-1:0] raddr,
  output logic [WIDTH-1:0] rdata_q
);
  logic [WIDTH-1:0] mem_q [DEPTH];

  // storage carries no reset; empty and full flags say what is valid
  always_ff @(posedge pclk) begin
    if (we) begin
      mem_q[waddr] <= wdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_q <= '0;
    end else if (re) begin
      rdata_q <= mem_q[raddr];
    end
  end
endmodule : psbs_mem
`default_nettype wire

// *** tb/psbs_host_model.sv ***
// behavioural model of the external host that drives the slave port pins
`default_nettype none
module psbs_host_model (
  input wire logic pclk,
  output var psbs_pkg::psbs_host_req_s host_req
);
  timeunit 1ns;
  timeprecision 1ps;
  import psbs_pkg::*;
  initial host_req = '0;
  //////////////////////////////////////////////////////////////////////////////
  // one strobe pulse per access; released lines carry inverted values so stale data never helps
  task automatic access(input logic rd, input logic wr, input logic [SLOT_W-1:0] a,
                        input logic [BYTE_W-1:0] d);
    @(posedge pclk);
    host_req <= '{rd: rd, wr: wr, addr: a, wdata: d};
    @(posedge pclk);
    host_req <= '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
  endtask : access
endmodule : psbs_host_model
`default_nettype wire

// *** tb/psbs_top_tb_top.sv ***
// self-checking bench for the parallel slave buffer status block
`default_nettype none
module psbs_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import psbs_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  psbs_apb_req_s apb_req = '0;
  psbs_host_req_s host_req;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [BYTE_W-1:0] host_rdata;
  logic [PAD_W-1:0] pad_cfg;
  logic irq;
  logic [31:0] rd_q;
  logic err_q;
  int error_cnt = 0;
  int checked = 0;
  always #5 pclk = ~pclk;
  psbs_top psbs_top_i (.pclk(pclk), .presetn(presetn), .apb_req(apb_req), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .host_req(host_req), .host_rdata(host_rdata),
    .pad_cfg(pad_cfg), .irq(irq));
  psbs_host_model psbs_host_model_i (.pclk(pclk), .host_req(host_req));
  //////////////////////////////////////////////////////////////////////////////
  task automatic stop_test;
    if (error_cnt == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : stop_test
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      $display("wrong value %s expected %h seen %h", name, exp, got);
      error_cnt++;
    end
  endtask : chk
  // signals move right after a rising edge; answer and read data are taken at that edge
  task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
    @(posedge pclk);
    apb_req.penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 50) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 50) begin
      error_cnt++;
      stop_test();
    end
    rd_q = prdata;
    err_q = pslverr;
    apb_req <= '0;
    // flops written at the access edge settle before callers look at outputs
    @(negedge pclk);
  endtask : apb
  task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [31:0] exp, input string name);
    apb(1'b0, a, 32'h0);
    chk(name, exp, rd_q);
  endtask : rd_chk
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rd_chk(OFF_STAT, 32'h0000008f, "status after reset");
    apb(1'b1, OFF_PAD_CFG, 32'h00000005);
    chk("pad_cfg", 32'h5, {29'h0, pad_cfg});
    apb(1'b1, OFF_OUT_BASE + 8'h04, 32'h0000005a);
    rd_chk(OFF_STAT, 32'h0000000d, "status out slot loaded");
    psbs_host_model_i.access(1'b1, 1'b0, 2'h1, 8'h00);
    @(negedge pclk);
    chk("host_rdata", 32'h5a, {24'h0, host_rdata});
    rd_chk(OFF_STAT, 32'h0000008f, "status out slot read");
    apb(1'b1, OFF_IRQ_MASK, 32'h00000003);
    psbs_host_model_i.access(1'b1, 1'b0, 2'h1, 8'h00);
    rd_chk(OFF_STAT, 32'h000000cf, "status underflow");
    chk("irq underflow", 32'h1, {31'h0, irq});
    apb(1'b1, OFF_STAT, 32'h00000040);
    rd_chk(OFF_STAT, 32'h000000cf, "underflow kept on one");
    apb(1'b1, OFF_STAT, 32'h00000000);
    rd_chk(OFF_STAT, 32'h0000008f, "underflow cleared");
    apb(1'b1, OFF_IRQ_STAT, 32'h00000001);
    chk("irq cleared", 32'h0, {31'h0, irq});
    // host drains slot 0 at the edge right after software fills it
    fork
      apb(1'b1, OFF_OUT_BASE, 32'h0000003c);
      begin
        repeat (2) @(posedge pclk);
        psbs_host_model_i.access(1'b1, 1'b0, 2'h0, 8'h00);
      end
    join
    @(negedge pclk);
    chk("host_rdata slot 0", 32'h3c, {24'h0, host_rdata});
    rd_chk(OFF_STAT, 32'h0000008f, "status slot 0 drained");
    for (int i = 0; i < 4; i++) begin
      psbs_host_model_i.access(1'b0, 1'b1, 2'(i), 8'h10 + 8'(i));
    end
    rd_chk(OFF_STAT, 32'h00008f8f, "status in all full");
    psbs_host_model_i.access(1'b0, 1'b1, 2'h2, 8'hee);
    rd_chk(OFF_STAT, 32'h0000cf8f, "status overflow");
    chk("irq overflow", 32'h1, {31'h0, irq});
    rd_chk(OFF_IRQ_STAT, 32'h0000000e, "irq status");
    rd_chk(OFF_IN_BASE + 8'h08, 32'h00000012, "in slot 2 data");
    rd_chk(OFF_STAT, 32'h00004b8f, "status in slot 2 read");
    apb(1'b1, 8'hfc, 32'h0000ffff);
    chk("pslverr unmapped", 32'h1, {31'h0, err_q});
    stop_test();
  end
endmodule : psbs_top_tb_top
`default_nettype wire
